/* File: pkg/mscr_params.svh */
`ifndef MSCR_PARAMS_SVH
`define MSCR_PARAMS_SVH

// ==========================================================
// configuration word layout
`define MSCR_WORD_BITS        56
`define MSCR_THR_LSB          15
`define MSCR_THR_MSB          22
`define MSCR_PULSE_BIT        23
`define MSCR_STEP_LSB         24
`define MSCR_STEP_MSB         25
`define MSCR_TYPE_LSB         26
`define MSCR_TYPE_MSB         28
`define MSCR_THR_SCALE_SHIFT  3
`define MSCR_WORD_DEFAULT     56'h00000003_0e0000
`define MSCR_TYPE_BYPASS      3'h3
`define MSCR_THR_DEFAULT      8'h1c
`define MSCR_MAG_DEFAULT      11'h0e0
`define MSCR_STEP_DEFAULT     2'h3
`define MSCR_TYPE_DEFAULT     3'h0

// ==========================================================
// serial link constants
`define MSCR_GENCALL_BYTE     8'h00
`define MSCR_TEN_BIT_PREFIX   5'h1e
`define MSCR_WORD_BYTES       3'h7
`define MSCR_BITS_PER_BYTE    4'h8
`define MSCR_DEFAULT_ADDR     10'h301

`endif

/* File: pkg/mscr_pkg.sv */
`default_nettype none

package mscr_pkg;

    // ==========================================================
    // receiver states, gray along idle -> address -> data -> skip
    typedef enum logic [2:0] {
        MSCR_IDLE   = 3'h0,
        MSCR_ADR_HI = 3'h1,
        MSCR_ADR_LO = 3'h3,
        MSCR_DATA   = 3'h2,
        MSCR_SKIP   = 3'h6
    } mscr_state_t;

endpackage : mscr_pkg

`default_nettype wire

/* File: hdl/mscr_config_register.sv */
// What this block does
// RQ1: The host ignores samples and motion pulses for the settling interval after power-up or a filter change.
// RQ2: The block holds one 56-bit configuration word that governs all programmable operation.
// RQ3: The host writes zero into bits 0 to 14 and 29 to 55, which the block stores but never decodes.
// RQ4: The 8-bit threshold field is taken from word bits 22 (msb) down to 15 (lsb).
// RQ5: Any threshold value 0 to 255 is accepted and the compare magnitude is eight times that value.
// RQ6: The scaled threshold forms symmetric positive and negative limits of a window on the filter output.
// RQ7: Bit 23 enables the motion pulse mode when 1, and it resets to disabled.
// RQ8: Bits 25:24 select the gain step, 01 lowest, 11 middle, 00 highest, with 11 after reset.
// RQ9: Bits 28:26 select the filter type, 000 after reset, and 011 bypasses the filter.
// RQ10: The word follows the address straight away with no sub-address, bit 55 first.
// RQ11: Without any write after power-up the default threshold, step and type are in force.
// RQ12: A write is accepted after a 10-bit address or after a 7-bit general call.
// RQ13: The active word changes only once all 56 bits of a write have arrived.
`include "mscr_params.svh"
`default_nettype none

module mscr_config_register #(
    parameter logic [9:0] DEV_ADDR = `MSCR_DEFAULT_ADDR
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    // serial pins, open drain data
    input  wire logic         scl_in,
    input  wire logic         shared_data_motion_pin_in,
    output logic              shared_data_motion_pin_out,
    output logic              shared_data_motion_pin_oe,
    // filter output samples
    input  wire logic [11:0]  bpf_sample,
    input  wire logic         bpf_valid,
    // decoded configuration
    output logic [55:0]       sensor_configuration_word,
    output logic [7:0]        threshold_level_field,
    output logic [10:0]       threshold_magnitude,
    output logic              motion_pulse_mode_enable,
    output logic [1:0]        filter_gain_step_select,
    output logic [2:0]        filter_type_select,
    output logic              filter_bypass,
    output logic              filter_settings_changed,
    // window comparator result
    output logic              window_exceeded
);

    // ==========================================================
    // pin synchronisers
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;

    // three stages: first two synchronise, third gives edges
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], shared_data_motion_pin_in};
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // bus conditions from stable stages only
    assign scl_rise   = scl_sync[1] & ~scl_sync[2];
    assign scl_fall   = ~scl_sync[1] & scl_sync[2];
    assign start_seen = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
    assign stop_seen  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

    // ==========================================================
    // bit receiver
    logic [7:0] byte_reg;
    logic [3:0] bit_cnt_reg;

    // ninth clock is the acknowledge slot, nothing shifted then
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            byte_reg    <= 8'h00;
            bit_cnt_reg <= 4'h0;
        end else if (start_seen) begin
            bit_cnt_reg <= 4'h0;
        end else if (scl_rise) begin
            if (bit_cnt_reg == `MSCR_BITS_PER_BYTE) begin
                bit_cnt_reg <= 4'h0;
            end else begin
                byte_reg    <= {byte_reg[6:0], sda_sync[1]}; // msb first [RQ10]
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    logic byte_done;
    assign byte_done = scl_fall && (bit_cnt_reg == `MSCR_BITS_PER_BYTE) && !shared_data_motion_pin_oe;

    // ==========================================================
    // address match and transfer sequencing
    mscr_pkg::mscr_state_t state_reg;
    logic [2:0]            byte_cnt_reg;
    logic [47:0]           collect_reg;
    logic                  ack_next;
    logic                  commit;

    // byte decision, only meaningful while byte_done
    always_comb begin
        ack_next = 1'b0;
        commit   = 1'b0;
        unique case (state_reg)
            mscr_pkg::MSCR_ADR_HI: begin
                ack_next = (byte_reg == `MSCR_GENCALL_BYTE) ||
                           (byte_reg == {`MSCR_TEN_BIT_PREFIX, DEV_ADDR[9:8], 1'b0}); // [RQ12]
            end
            mscr_pkg::MSCR_ADR_LO: begin
                ack_next = (byte_reg == DEV_ADDR[7:0]);
            end
            mscr_pkg::MSCR_DATA: begin
                ack_next = 1'b1;
                commit   = (byte_cnt_reg == (`MSCR_WORD_BYTES - 3'h1)); // last byte [RQ13]
            end
            mscr_pkg::MSCR_IDLE,
            mscr_pkg::MSCR_SKIP: begin
                ack_next = 1'b0;
            end
            default: begin
                ack_next = 1'b0;
            end
        endcase
    end

    // state: no sub-address, data follows address directly
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= mscr_pkg::MSCR_IDLE;
            byte_cnt_reg <= 3'h0;
        end else if (start_seen) begin
            state_reg    <= mscr_pkg::MSCR_ADR_HI;
            byte_cnt_reg <= 3'h0;
        end else if (stop_seen) begin
            state_reg    <= mscr_pkg::MSCR_IDLE;
        end else if (byte_done) begin
            unique case (state_reg)
                mscr_pkg::MSCR_ADR_HI: begin
                    if (!ack_next) begin
                        state_reg <= mscr_pkg::MSCR_SKIP;
                    end else if (byte_reg == `MSCR_GENCALL_BYTE) begin
                        state_reg <= mscr_pkg::MSCR_DATA; // [RQ10]
                    end else begin
                        state_reg <= mscr_pkg::MSCR_ADR_LO;
                    end
                end
                mscr_pkg::MSCR_ADR_LO: begin
                    state_reg <= ack_next ? mscr_pkg::MSCR_DATA : mscr_pkg::MSCR_SKIP; // [RQ12]
                end
                mscr_pkg::MSCR_DATA: begin
                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                    if (commit) begin
                        state_reg <= mscr_pkg::MSCR_SKIP;
                    end
                end
                mscr_pkg::MSCR_IDLE,
                mscr_pkg::MSCR_SKIP: begin
                    state_reg <= state_reg;
                end
                default: begin
                    state_reg <= mscr_pkg::MSCR_IDLE;
                end
            endcase
        end
    end

    // staging of the first six bytes, bit 55 arrives first
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            collect_reg <= 48'h0;
        end else if (byte_done && (state_reg == mscr_pkg::MSCR_DATA)) begin
            collect_reg <= {collect_reg[39:0], byte_reg}; // [RQ10]
        end
    end

    // acknowledge drive, low during the ninth clock only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shared_data_motion_pin_oe <= 1'b0;
        end else if (start_seen || stop_seen) begin
            shared_data_motion_pin_oe <= 1'b0;
        end else if (byte_done && ack_next) begin
            shared_data_motion_pin_oe <= 1'b1;
        end else if (scl_fall && (bit_cnt_reg == 4'h0)) begin
            shared_data_motion_pin_oe <= 1'b0;
        end
    end

    // data level is always low, the enable decides
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shared_data_motion_pin_out <= 1'b0;
        end else begin
            shared_data_motion_pin_out <= 1'b0;
        end
    end

    // ==========================================================
    // active configuration word
    logic [55:0] word_next;
    assign word_next = {collect_reg, byte_reg};

    // whole word loaded at once, defaults until then
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sensor_configuration_word <= `MSCR_WORD_DEFAULT; // [RQ2] [RQ11]
        end else if (byte_done && commit) begin
            sensor_configuration_word <= word_next; // reserved bits kept, unused [RQ3] [RQ13]
        end
    end

    // field decode, registered so outputs come from flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            threshold_level_field    <= `MSCR_THR_DEFAULT;
            threshold_magnitude      <= `MSCR_MAG_DEFAULT;
            motion_pulse_mode_enable <= 1'b0;
            filter_gain_step_select  <= `MSCR_STEP_DEFAULT;
            filter_type_select       <= `MSCR_TYPE_DEFAULT;
            filter_bypass            <= 1'b0;
        end else begin
            threshold_level_field    <= sensor_configuration_word[`MSCR_THR_MSB:`MSCR_THR_LSB]; // [RQ4]
            threshold_magnitude      <= {sensor_configuration_word[`MSCR_THR_MSB:`MSCR_THR_LSB],
                                         3'h0}; // times eight [RQ5]
            motion_pulse_mode_enable <= sensor_configuration_word[`MSCR_PULSE_BIT]; // [RQ7]
            filter_gain_step_select  <= sensor_configuration_word[`MSCR_STEP_MSB:`MSCR_STEP_LSB]; // [RQ8]
            filter_type_select       <= sensor_configuration_word[`MSCR_TYPE_MSB:`MSCR_TYPE_LSB]; // [RQ9]
            filter_bypass            <= (sensor_configuration_word[`MSCR_TYPE_MSB:`MSCR_TYPE_LSB]
                                         == `MSCR_TYPE_BYPASS); // [RQ9]
        end
    end

    // pulse when a write alters step or type, start of settling
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            filter_settings_changed <= 1'b0;
        end else begin
            filter_settings_changed <= byte_done && commit &&
                (word_next[`MSCR_TYPE_MSB:`MSCR_STEP_LSB] !=
                 sensor_configuration_word[`MSCR_TYPE_MSB:`MSCR_STEP_LSB]); // [RQ1]
        end
    end

    // ==========================================================
    // window comparator on signed filter samples
    logic signed [12:0] sample_ext;
    logic signed [12:0] limit_pos;
    logic signed [12:0] limit_neg;

    assign sample_ext = {bpf_sample[11], bpf_sample};
    assign limit_pos  = {2'h0, threshold_magnitude};
    assign limit_neg  = 13'h0 - limit_pos;

    // outside plus or minus limit flags the sample
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            window_exceeded <= 1'b0;
        end else if (bpf_valid) begin
            window_exceeded <= (sample_ext > limit_pos) || (sample_ext < limit_neg); // [RQ6]
        end
    end

endmodule : mscr_config_register

`default_nettype wire

/* File: verification/mscr_host_model.sv */
`default_nettype none
// ==========================================================
// host side serial master, open drain data
module mscr_host_model (
    // system clock paces the bus
    input  wire logic clk_sys,
    // resolved data line
    input  wire logic sda_in,
    // driven lines
    output logic      scl_out,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus released high
    initial begin
        scl_out = 1'b1;
        sda_low = 1'b0;
    end
    // quarter bit of five clocks, above the four clock minimum
    task automatic q_wait();
        repeat (5) @(posedge clk_sys);
        #1;
    endtask : q_wait
    // one bit, data set while clock low, read mid high
    task automatic bit_xfer(input logic b, output logic rd);
        sda_low = !b;
        q_wait();
        scl_out = 1'b1;
        q_wait();
        rd = sda_in;
        q_wait();
        scl_out = 1'b0;
        q_wait();
    endtask : bit_xfer
    // byte msb first, then ninth clock for the ack
    task automatic byte_xfer(input logic [7:0] d, inout int acks);
        logic rd;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], rd);
        bit_xfer(1'b1, rd);
        acks += int'(!rd);
    endtask : byte_xfer
    // whole write: start, address, nb bytes (word msb first, ff after the seventh), stop
    task automatic xfer(input logic gc, input logic [9:0] adr, input logic [55:0] w, input int nb, output int acks);
        acks = 0;
        sda_low = 1'b1;
        q_wait();
        scl_out = 1'b0;
        q_wait();
        if (gc) byte_xfer(8'h00, acks);
        else begin
            byte_xfer({5'h1e, adr[9:8], 1'b0}, acks);
            byte_xfer(adr[7:0], acks);
        end
        for (int i = 0; i < nb; i++) byte_xfer(i < 7 ? w[55 - 8 * i -: 8] : 8'hff, acks);
        sda_low = 1'b1;
        q_wait();
        scl_out = 1'b1;
        q_wait();
        sda_low = 1'b0;
        q_wait();
        q_wait();
    endtask : xfer
endmodule : mscr_host_model
`default_nettype wire

/* File: verification/mscr_config_register_sva.sv */
`default_nettype none
// ==========================================================
// port level checks of the configuration register
module mscr_config_register_sva (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // serial pins
    input wire logic        scl_in,
    input wire logic        shared_data_motion_pin_in,
    input wire logic        shared_data_motion_pin_out,
    input wire logic        shared_data_motion_pin_oe,
    // filter samples
    input wire logic [11:0] bpf_sample,
    input wire logic        bpf_valid,
    // configuration outputs
    input wire logic [55:0] sensor_configuration_word,
    input wire logic [7:0]  threshold_level_field,
    input wire logic [10:0] threshold_magnitude,
    input wire logic        motion_pulse_mode_enable,
    input wire logic [1:0]  filter_gain_step_select,
    input wire logic [2:0]  filter_type_select,
    input wire logic        filter_bypass,
    input wire logic        filter_settings_changed,
    input wire logic        window_exceeded
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // fields follow the word one clock later, the change pulse in the same clock as the word moves
    property p_thr; threshold_level_field == $past(sensor_configuration_word[22:15]); endproperty
    property p_mag; threshold_magnitude == {threshold_level_field, 3'h0}; endproperty
    property p_pulse; motion_pulse_mode_enable == $past(sensor_configuration_word[23]); endproperty
    property p_step; filter_gain_step_select == $past(sensor_configuration_word[25:24]); endproperty
    property p_type; filter_type_select == $past(sensor_configuration_word[28:26]); endproperty
    property p_byp; filter_bypass == (filter_type_select == 3'h3); endproperty
    property p_chg;
        filter_settings_changed == (sensor_configuration_word[28:24] != $past(sensor_configuration_word[28:24]));
    endproperty
    // word moves only at the ack of a full write
    property p_commit; $changed(sensor_configuration_word) |-> ##[0:6] shared_data_motion_pin_oe; endproperty
    // strict symmetric window on each valid sample
    property p_win;
        bpf_valid |=> window_exceeded == $past(($signed(bpf_sample) > $signed({1'b0, threshold_magnitude}))
            || ($signed(bpf_sample) < -$signed({1'b0, threshold_magnitude})));
    endproperty
    property p_hold; !bpf_valid |=> $stable(window_exceeded); endproperty
    // acknowledge only ever pulls the data line low
    property p_low; shared_data_motion_pin_oe |-> !shared_data_motion_pin_out; endproperty
    a_thr: assert property (p_thr) else $error("threshold field mismatch");
    a_mag: assert property (p_mag) else $error("magnitude not eight times field");
    a_pulse: assert property (p_pulse) else $error("pulse mode mismatch");
    a_step: assert property (p_step) else $error("gain step mismatch");
    a_type: assert property (p_type) else $error("filter type mismatch");
    a_byp: assert property (p_byp) else $error("bypass decode wrong");
    a_chg: assert property (p_chg) else $error("settings change pulse wrong");
    a_commit: assert property (p_commit) else $error("word changed outside ack");
    a_win: assert property (p_win) else $error("window result wrong");
    a_hold: assert property (p_hold) else $error("window result moved");
    a_low: assert property (p_low) else $error("data line driven high");
    c_chg: cover property (filter_settings_changed);
    c_win: cover property (bpf_valid ##1 window_exceeded);
    c_byp: cover property (filter_bypass);
    c_commit: cover property ($changed(sensor_configuration_word));
endmodule : mscr_config_register_sva
bind mscr_config_register mscr_config_register_sva u_sva (.clk_sys, .arst_n, .scl_in, .shared_data_motion_pin_in,
    .shared_data_motion_pin_out, .shared_data_motion_pin_oe, .bpf_sample, .bpf_valid, .sensor_configuration_word,
    .threshold_level_field, .threshold_magnitude, .motion_pulse_mode_enable, .filter_gain_step_select,
    .filter_type_select, .filter_bypass, .filter_settings_changed, .window_exceeded);
`default_nettype wire

/* File: verification/tb_top.sv */
`default_nettype none
// ==========================================================
// configuration register bench
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] thr; logic pls; logic [1:0] stp; logic [2:0] typ; logic byp;} mscr_row_t;
    // threshold, pulse, step, type, expected bypass
    localparam mscr_row_t ROWS [5] = '{'{8'h00, 1'b1, 2'h1, 3'h7, 1'b0}, '{8'hff, 1'b0, 2'h3, 3'h0, 1'b0},
        '{8'h10, 1'b1, 2'h0, 3'h1, 1'b0}, '{8'h64, 1'b0, 2'h1, 3'h2, 1'b0}, '{8'h10, 1'b0, 2'h3, 3'h3, 1'b1}};
    // sample table, bit 12 is the expected result
    localparam logic [12:0] SMP [6] = '{13'h0080, 13'h1081, 13'h0f80, 13'h1f7f, 13'h17ff, 13'h0000};
    logic        clk_sys = 1'b0, arst_n = 1'b0, bpf_valid = 1'b0, scl, hlow, dout, oe, sda;
    logic [11:0] bpf_sample = 12'h000;
    logic [55:0] word, w;
    logic [7:0]  thr;
    logic [10:0] mag;
    logic [2:0]  typ;
    logic [1:0]  stp;
    logic        pls, byp, chg, win;
    int          err_count = 0, comparisons = 0, acks;
    int          settle = 0, chg_count = 0;
    logic [25:0] exp_f;
    // host waits this many cycles after a filter change, arbitrary bench value
    localparam int SETTLE_CYCLES = 64;
    // clock and open drain data wire with pull-up
    always #20 clk_sys = ~clk_sys;
    assign sda = !(hlow || (oe && !dout));
    mscr_config_register DUT (.clk_sys, .arst_n, .scl_in(scl), .shared_data_motion_pin_in(sda),
        .shared_data_motion_pin_out(dout), .shared_data_motion_pin_oe(oe), .bpf_sample, .bpf_valid,
        .sensor_configuration_word(word), .threshold_level_field(thr), .threshold_magnitude(mag),
        .motion_pulse_mode_enable(pls), .filter_gain_step_select(stp), .filter_type_select(typ),
        .filter_bypass(byp), .filter_settings_changed(chg), .window_exceeded(win));
    mscr_host_model host (.clk_sys, .sda_in(sda), .scl_out(scl), .sda_low(hlow));
    // host view of the settling interval, restarted by each filter change
    always @(posedge clk_sys) begin
        if (chg === 1'b1) begin
            settle    <= SETTLE_CYCLES;
            chg_count <= chg_count + 1;
        end else if (settle > 0) begin
            settle <= settle - 1;
        end
    end
    task automatic chk(input logic [55:0] got, input logic [55:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // one write then check ack count and active word
    task automatic cfg(input logic gc, input logic [9:0] adr, input logic [55:0] d, input int nb, input int ea);
        host.xfer(gc, adr, d, nb, acks);
        repeat (4) @(posedge clk_sys);
        #1;
        chk(56'(acks), 56'(ea), "ack count");
        chk(word, w, "active word");
    endtask : cfg
    // watchdog
    initial begin
        #3ms;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(word, 56'h00000003_0e0000, "default word");
        chk({thr, mag, pls, stp, typ, byp}, {8'h1c, 11'h0e0, 1'b0, 2'h3, 3'h0, 1'b0}, "defaults");
        // table: both address kinds, reserved bits written zero
        foreach (ROWS[i]) begin
            w = {27'h0, ROWS[i].typ, ROWS[i].stp, ROWS[i].pls, ROWS[i].thr, 15'h0};
            cfg(i[0], 10'h301, w, 7, i[0] ? 8 : 9);
            exp_f = {ROWS[i].thr, 11'(ROWS[i].thr) * 11'h8, ROWS[i].pls, ROWS[i].stp, ROWS[i].typ, ROWS[i].byp};
            chk({thr, mag, pls, stp, typ, byp}, exp_f, "fields");
        end
        cfg(1'b1, 10'h301, 56'h0, 4, 5);
        cfg(1'b0, 10'h302, 56'h0, 7, 1);
        // window on magnitude 128, equal limit stays inside
        while (settle != 0) @(posedge clk_sys);
        foreach (SMP[i]) begin
            @(posedge clk_sys);
            #1 bpf_sample = SMP[i][11:0];
            bpf_valid = 1'b1;
            @(posedge clk_sys);
            #1 bpf_valid = 1'b0;
            bpf_sample = 12'h7ff;
            chk(56'(win), 56'(SMP[i][12]), "window");
        end
        repeat (3) @(posedge clk_sys);
        #1;
        chk(56'(win), 56'h0, "window hold");
        // extra ninth byte refused, word still taken
        w = 56'h00000003_0e0000;
        cfg(1'b1, 10'h301, w, 8, 8);
        // every write that moved step or type gave one settling hint
        chk(56'(chg_count), 56'h6, "settling hints");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
